/* File: owh_host.sv */
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
// Operation
// - bytes sent most significant bit first
// - line high two microseconds before each byte
// - start before address may be skipped
// - end-of-stream high two microseconds after byte; not after an ack-requested data byte, pulled low at once
// - long phase at least twice short phase
// - host holds low, releases, samples low ack
// - no new transfer until ack ends
// - ack requested only with open drain driver
// - profile write needs prior unlock 1101010
// - profile written over link in both modes
// - pwm mode: enable with 2-3ms high
// - device address byte is 72 hex
// - data byte: request, sub-address, payload
module owh_host (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ctrl_in,
    output logic             ctrl_out,
    output logic             ctrl_oe_n
);
    typedef enum logic [2:0] {
        OWH_IDLE,
        OWH_START,
        OWH_LOW,
        OWH_HIGH,
        OWH_EOS,
        OWH_ACKHOLD,
        OWH_ACKWAIT
    } owh_state_t;

    typedef struct packed {
        owh_state_t  state;
        logic [15:0] shreg;
        logic [4:0]  nbit;
        logic [19:0] cnt;
        logic        ack_req;
        logic        drive_low;
        logic        busy;
        logic        done;
        logic        ack_seen;
        logic        ack_req_seen;
        logic        line_ok;
    } owh_host_t;

    owh_host_t   st_q;
    owh_host_t   st_d;
    logic        go;
    logic [15:0] cmd;
    logic [15:0] unit_cyc;
    logic        line_s;

    // phase length of the current bit: a one is short low, long high
    function automatic logic [19:0] phase_len(input logic bitv, input logic low_ph, input logic [15:0] u);
        logic [19:0] sh;
        logic [19:0] lg;
        sh = {4'h0, u};
        lg = 20'(owh_pkg::OWH_RATIO) * {4'h0, u};
        phase_len = (bitv ^ low_ph) ? lg : sh;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register slave and line synchroniser
    owh_apb u_apb (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .busy         (st_q.busy),
        .done         (st_q.done),
        .ack_seen     (st_q.ack_seen),
        .ack_req_seen (st_q.ack_req_seen),
        .go           (go),
        .cmd          (cmd),
        .unit_cyc     (unit_cyc)
    );

    owh_sync u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .din     (ctrl_in),
        .dout    (line_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer; cmd[7:0] is the data byte, skip bit drops the start when the sensed line is high
    always_comb begin
        st_d           = st_q;
        st_d.line_ok   = line_s;
        case (st_q.state)
            OWH_IDLE: begin
                // released while idle, so an enable sees a steady high line
                st_d.drive_low = 1'b0;
                if (go) begin
                    st_d.busy     = 1'b1;
                    st_d.done     = 1'b0;
                    st_d.ack_seen = 1'b0;
                    st_d.shreg    = {owh_pkg::OWH_DEV_ADDR, cmd[7:0]};
                    st_d.ack_req  = cmd[owh_pkg::OWH_ACKREQ_BIT];
                    st_d.ack_req_seen = cmd[owh_pkg::OWH_ACKREQ_BIT];
                    st_d.nbit     = 5'd0;
                    st_d.cnt      = 20'(owh_pkg::OWH_START_CYC);
                    // line already high and released: start may be skipped
                    if (line_s && cmd[owh_pkg::OWH_SKIP_BIT]) begin
                        st_d.state = OWH_LOW;
                        st_d.cnt   = phase_len(owh_pkg::OWH_DEV_ADDR[7], 1'b1, unit_cyc);
                    end else begin
                        st_d.state = OWH_START;
                    end
                end
            end
            OWH_START: begin
                st_d.drive_low = 1'b0;
                if (st_q.cnt > 20'd1) begin
                    st_d.cnt = st_q.cnt - 20'd1;
                end else begin
                    st_d.state = OWH_LOW;
                    st_d.cnt   = phase_len(st_q.shreg[15], 1'b1, unit_cyc);
                end
            end
            OWH_LOW: begin
                st_d.drive_low = 1'b1;
                if (st_q.cnt > 20'd1) begin
                    st_d.cnt = st_q.cnt - 20'd1;
                end else begin
                    st_d.state = OWH_HIGH;
                    st_d.cnt   = phase_len(st_q.shreg[15], 1'b0, unit_cyc);
                end
            end
            OWH_HIGH: begin
                st_d.drive_low = 1'b0;
                if (st_q.cnt > 20'd1) begin
                    st_d.cnt = st_q.cnt - 20'd1;
                end else begin
                    st_d.shreg = {st_q.shreg[14:0], 1'b0};
                    st_d.nbit  = st_q.nbit + 5'd1;
                    if (st_q.nbit == 5'd7 || st_q.nbit == 5'd15) begin
                        // no closing falling edge: the last bit's high phase runs on into the eos
                        st_d.state = OWH_EOS;
                        st_d.cnt   = 20'(owh_pkg::OWH_EOS_CYC);
                    end else begin
                        st_d.state = OWH_LOW;
                        st_d.cnt   = phase_len(st_q.shreg[14], 1'b1, unit_cyc);
                    end
                end
            end
            OWH_EOS: begin
                // after the data byte with ack requested the line goes low at once and stays low
                if (st_q.nbit == 5'd16 && st_q.ack_req) begin
                    st_d.drive_low = 1'b1;
                    st_d.state     = OWH_ACKHOLD;
                    st_d.cnt       = 20'(owh_pkg::OWH_ACK_VALID_CYC);
                end else if (st_q.cnt > 20'd1) begin
                    st_d.drive_low = 1'b0;
                    st_d.cnt       = st_q.cnt - 20'd1;
                end else if (st_q.nbit == 5'd16) begin
                    st_d.state = OWH_IDLE;
                    st_d.busy  = 1'b0;
                    st_d.done  = 1'b1;
                end else begin
                    // eos doubles as start of the data byte
                    st_d.state = OWH_LOW;
                    st_d.cnt   = phase_len(st_q.shreg[15], 1'b1, unit_cyc);
                end
            end
            OWH_ACKHOLD: begin
                st_d.drive_low = 1'b1;
                if (st_q.cnt > 20'd1) begin
                    st_d.cnt = st_q.cnt - 20'd1;
                end else begin
                    st_d.drive_low = 1'b0;
                    st_d.state     = OWH_ACKWAIT;
                    st_d.cnt       = 20'(owh_pkg::OWH_ACK_MAX_CYC);
                end
            end
            OWH_ACKWAIT: begin
                st_d.drive_low = 1'b0;
                // skip three cycles, past the two sync stages, before trusting the sampled level
                if (st_q.cnt == 20'(owh_pkg::OWH_ACK_MAX_CYC - 3) && !line_s) begin
                    st_d.ack_seen = 1'b1;
                end
                // stay busy until the line is back high or time runs out
                if ((line_s && st_q.cnt < 20'(owh_pkg::OWH_ACK_MAX_CYC - 3)) || st_q.cnt == 20'd1) begin
                    st_d.state = OWH_IDLE;
                    st_d.busy  = 1'b0;
                    st_d.done  = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt - 20'd1;
                end
            end
            default: begin
                st_d.state = OWH_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{state: OWH_IDLE, shreg: 16'h0000, nbit: 5'd0, cnt: 20'h00000,
                      ack_req: 1'b0, drive_low: 1'b0, busy: 1'b0, done: 1'b0,
                      ack_seen: 1'b0, ack_req_seen: 1'b0, line_ok: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // open drain: drive only low, enable active low
    assign ctrl_out  = 1'b0;
    assign ctrl_oe_n = !st_q.drive_low;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_addr_msb_first: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_IDLE && go) |=> st_q.shreg[15:8] == 8'h72)
        else $error("address byte not loaded");
    a_start_high: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_START) |-> !st_q.drive_low)
        else $error("line driven during start");
    // drive_low trails the state by one cycle, so look one cycle after high
    a_low_then_high: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_HIGH) |=> !st_q.drive_low)
        else $error("high phase not released");
    a_eos_released: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_EOS && !st_q.ack_req) |-> !st_q.drive_low)
        else $error("line driven during eos");
    a_ack_hold_low: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(st_q.state == OWH_ACKHOLD) |-> st_q.drive_low[*8])
        else $error("line released inside validity delay");
    a_no_ack_unasked: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_ACKHOLD) |-> st_q.ack_req)
        else $error("ack hold without request");
    a_ack_wait_free: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_ACKWAIT) |-> !st_q.drive_low)
        else $error("line driven while sampling ack");
    a_busy_block: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state != OWH_IDLE) |-> st_q.busy)
        else $error("busy low mid transfer");
    // idle line left to the pull-up, also while the chip is being enabled
    a_idle_released: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_IDLE) |-> ctrl_oe_n)
        else $error("line driven while idle");
    a_start_unless_skip: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_IDLE && go && !(line_s && cmd[owh_pkg::OWH_SKIP_BIT])) |=> st_q.state == OWH_START)
        else $error("start condition skipped");
    a_shift_msb: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_HIGH && st_q.cnt == 20'd1) |=> st_q.shreg == {$past(st_q.shreg[14:0]), 1'b0})
        else $error("bit not shifted msb first");
    a_ack_wait_bound: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_ACKWAIT && st_q.cnt == 20'd1) |=> st_q.state == OWH_IDLE)
        else $error("ack wait overran");
    a_go_clears_done: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_IDLE && go) |=> st_q.busy && !st_q.done && !st_q.ack_seen)
        else $error("status not cleared at go");
    a_ack_req_latched: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == OWH_IDLE && go) |=> st_q.ack_req == $past(cmd[owh_pkg::OWH_ACKREQ_BIT]))
        else $error("ack request not latched");
    c_second_byte: cover property (@(posedge sys_clk) disable iff (!resetn)
        st_q.state == OWH_EOS && st_q.nbit == 5'd8 && st_q.cnt == 20'd1);
    c_plain_write: cover property (@(posedge sys_clk) disable iff (!resetn)
        st_q.state == OWH_EOS && st_q.nbit == 5'd16 && !st_q.ack_req);
    c_ack_done: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(st_q.ack_seen));
    c_skip_start: cover property (@(posedge sys_clk) disable iff (!resetn)
        st_q.state == OWH_IDLE && go && line_s && cmd[owh_pkg::OWH_SKIP_BIT]);
endmodule

/* File: owh_pkg.sv */
package owh_pkg;
    // apb register map of the controller, one aligned word each
    localparam logic [7:0] OWH_CTRL_OFF   = 8'h00; // write: go, byte fields; read: byte fields
    localparam logic [7:0] OWH_STATUS_OFF = 8'h04; // read: busy, done, ack seen, ack requested
    localparam logic [7:0] OWH_TIMING_OFF = 8'h08; // read/write: unit time in cycles
    // control word field positions
    localparam int OWH_GO_BIT      = 31;
    localparam int OWH_ACKREQ_BIT  = 7;
    localparam int OWH_SKIP_BIT    = 14;
    // data byte layout: ack request, sub-address, payload
    localparam int OWH_SUBADDR_LSB = 5;
    // device address byte
    localparam logic [7:0] OWH_DEV_ADDR = 8'h72;
    // unlock key and edge profile sub-address codes
    localparam logic [1:0] OWH_SUB_UNLOCK = 2'h3;
    localparam logic [1:0] OWH_SUB_EMI    = 2'h2;
    localparam logic [4:0] OWH_UNLOCK_PAYLOAD = 5'h0A;
    localparam logic [1:0] OWH_EMI_RESET = 2'h0;
    // timing, in ns, and derived cycle counts at 20 MHz
    localparam int OWH_CLK_NS       = 50;
    localparam int OWH_START_NS     = 2000;
    localparam int OWH_EOS_NS       = 2000;
    localparam int OWH_ACK_VALID_NS = 2000;
    localparam int OWH_ACK_MAX_NS   = 512000;
    localparam int OWH_START_CYC    = (OWH_START_NS + OWH_CLK_NS - 1) / OWH_CLK_NS;
    localparam int OWH_EOS_CYC      = (OWH_EOS_NS + OWH_CLK_NS - 1) / OWH_CLK_NS;
    localparam int OWH_ACK_VALID_CYC = (OWH_ACK_VALID_NS + OWH_CLK_NS - 1) / OWH_CLK_NS;
    localparam int OWH_ACK_MAX_CYC  = OWH_ACK_MAX_NS / OWH_CLK_NS;
    // default short phase of a bit cell; long phase is three times it
    localparam logic [15:0] OWH_UNIT_RESET = 16'h0014;
    localparam int OWH_RATIO = 3;
endpackage

/* File: owh_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser for the sensed control line
module owh_sync (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } owh_sync_t;
    owh_sync_t st_q;
    owh_sync_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    // idle line is high, so reset to high
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{s1: 1'b1, s2: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;
endmodule

/* File: owh_apb.sv */
`timescale 1ns/10ps
// apb slave holding the controller's own registers
module owh_apb (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        busy,
    input  wire logic        done,
    input  wire logic        ack_seen,
    input  wire logic        ack_req_seen,
    output logic             go,
    output logic [15:0]      cmd,
    output logic [15:0]      unit_cyc
);
    typedef struct packed {
        logic        go;
        logic [15:0] cmd;
        logic [15:0] unit;
    } owh_apb_t;
    owh_apb_t st_q;
    owh_apb_t st_d;
    logic     wr_acc;

    ////////////////////////////////////////////////////////////////////////
    // write decode; go is a one-cycle pulse, ignored while busy
    assign wr_acc = psel && penable && pwrite;
    always_comb begin
        st_d    = st_q;
        st_d.go = 1'b0;
        if (wr_acc && paddr == owh_pkg::OWH_CTRL_OFF) begin
            st_d.cmd = pwdata[15:0];
            st_d.go  = pwdata[owh_pkg::OWH_GO_BIT] && !busy;
        end else if (wr_acc && paddr == owh_pkg::OWH_TIMING_OFF) begin
            st_d.unit = pwdata[15:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{go: 1'b0, cmd: 16'h0000, unit: owh_pkg::OWH_UNIT_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    // read mux; zero-wait slave, unmapped reads zero with error
    always_comb begin
        prdata  = 32'h00000000;
        pslverr = 1'b0;
        if (paddr == owh_pkg::OWH_CTRL_OFF) begin
            prdata = {16'h0000, st_q.cmd};
        end else if (paddr == owh_pkg::OWH_STATUS_OFF) begin
            prdata = {28'h0000000, ack_req_seen, ack_seen, done, busy};
        end else if (paddr == owh_pkg::OWH_TIMING_OFF) begin
            prdata = {16'h0000, st_q.unit};
        end else begin
            pslverr = psel && penable;
        end
    end

    assign pready   = 1'b1;
    assign go       = st_q.go;
    assign cmd      = st_q.cmd;
    assign unit_cyc = st_q.unit;
endmodule

/* File: owh_dev_model.sv */
`timescale 1ns/10ps
// behavioural device on the far end of the control line, one-wire dimming mode only
module owh_dev #(
    parameter logic [7:0] DEV_ADDR = 8'h72, // own device address
    parameter int         EOS_C    = 40,    // end-of-stream, 2 us at 50 ns
    parameter int         VALID_C  = 38     // just under the host's low hold, so the two overlap
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        line,
    input  wire logic [15:0] ack_cyc,
    output logic             pull,
    output logic             rx_valid,
    output logic [15:0]      rx_word,
    output logic [1:0]       profile,
    output logic             unlock
);
    int          lo;
    int          hi;
    int          per;
    int          nbits;
    int          ack_t;
    logic        prev;
    logic        open;
    logic        bad;
    logic        acking;
    logic [15:0] sr;

    ////////////////////////////////////////////////////////////////////////////////
    // ratio decode of one cell, shifted in msb first
    task decode(input int h);
        if (h >= 2 * lo) sr = {sr[14:0], 1'b1};
        else if (lo >= 2 * h) sr = {sr[14:0], 1'b0};
        else bad = 1'b1;
        nbits++;
    endtask

    // end of the 16-bit frame: register write and ack decision
    task close_xfer(input logic fell);
        rx_valid <= !bad;
        rx_word  <= sr;
        if (!bad && sr[15:8] == DEV_ADDR) begin
            if (sr[6:5] == 2'b11 && sr[4:0] == 5'h0A) unlock <= 1'b1;
            else begin
                if (sr[6:5] == 2'b10 && unlock) profile <= sr[1:0];
                unlock <= 1'b0;
            end
            acking = sr[7] && fell;
        end
        nbits = 0;
        bad   = 1'b0;
        open  = 1'b0;
        ack_t = 0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // cells run fall to fall; last cell of a byte ends on a long high (EOS)
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pull     <= 1'b0;
            rx_valid <= 1'b0;
            rx_word  <= 16'h0000;
            profile  <= 2'h0;
            unlock   <= 1'b0;
            prev     = 1'b1;
            open     = 1'b0;
            bad      = 1'b0;
            acking   = 1'b0;
            nbits    = 0;
            sr       = 16'h0000;
            lo       = 0;
            hi       = 0;
            per      = 0;
            ack_t    = 0;
        end else begin
            rx_valid <= 1'b0;
            if (acking) begin
                ack_t++;
                pull <= (ack_t >= VALID_C) && (ack_t < VALID_C + int'(ack_cyc));
                if (ack_t >= VALID_C + int'(ack_cyc)) acking = 1'b0;
            end else if (prev && !line) begin
                if (open) begin
                    per = lo + hi;
                    decode(hi);
                end
                if (nbits == 16) close_xfer(1'b1);
                else begin
                    open = 1'b1;
                    lo   = 0;
                    hi   = 0;
                end
            end else if (!line) lo++;
            else if (open) begin
                hi++;
                // high phase guessed from the previous cell's period
                if (nbits % 8 == 7 && hi >= per - lo + EOS_C / 2) begin
                    decode(per - lo);
                    open = 1'b0;
                    if (nbits == 16 && !sr[7]) close_xfer(1'b0);
                end
            end
            prev = line;
        end
    end
endmodule

/* File: tb_one_wire_cmd_receiver.sv */
`timescale 1ns/10ps
module tb_one_wire_cmd_receiver;
    logic        sys_clk = 1'b0;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ctrl_out;
    logic        ctrl_oe_n;
    logic        line;
    logic        dev_pull;
    logic [15:0] ack_cyc;
    logic        rx_valid;
    logic [15:0] rx_word;
    logic [1:0]  profile;
    logic        unlock;
    logic [31:0] rdata;
    logic        rerr;
    logic [15:0] exp_q[$];
    int          n_fail = 0;
    int          n_tests = 0;
    int          seed = 32'h1C7C;
    int          r;

    ////////////////////////////////////////////////////////////////////////////////
    // open-drain wire with pull-up
    assign line = ((!ctrl_oe_n && !ctrl_out) || dev_pull) ? 1'b0 : 1'b1;
    always #25 sys_clk = ~sys_clk;

    owh_host u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctrl_in(line), .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n)
    );
    owh_dev u_dev (
        .sys_clk(sys_clk), .resetn(resetn), .line(line), .ack_cyc(ack_cyc), .pull(dev_pull),
        .rx_valid(rx_valid), .rx_word(rx_word), .profile(profile), .unlock(unlock)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop();
        $display("counts: %0d mismatches, %0d comparisons", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
        end
    endtask

    task bail(input string m);
        n_fail++;
        $display("[ERR] %0t %s", $time, m);
        report_and_stop();
    endtask

    // one apb transfer; answer taken at the rising edge that sees pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) bail("apb hang");
        rdata   = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task go(input logic [7:0] db, input logic skip);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[owh_pkg::OWH_GO_BIT] = 1'b1;
        w[owh_pkg::OWH_SKIP_BIT] = skip;
        w[7:0] = db;
        apb(1'b1, owh_pkg::OWH_CTRL_OFF, w);
    endtask

    // poll until idle and done, then wait for the device to report the word
    task wait_done(input logic exp_ack);
        int i;
        for (i = 0; i < 5000; i++) begin
            apb(1'b0, owh_pkg::OWH_STATUS_OFF, 32'h0000_0000);
            if (rdata[0] === 1'b0 && rdata[1] === 1'b1) break;
        end
        if (i == 5000) bail("transfer hang");
        chk(rdata[2], exp_ack, "ack flag");
        for (i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge sys_clk);
        chk(exp_q.size(), 32'h0, "word not seen");
    endtask

    task xfer(input logic [7:0] db, input logic skip);
        exp_q.push_back({8'h72, db});
        go(db, skip);
        wait_done(db[7]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitor: every decoded word takes the oldest expectation
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) bail("unexpected transfer");
            else chk(rx_word, exp_q.pop_front(), "received word");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        ack_cyc = 16'h00C8;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        chk(ctrl_oe_n, 1'b1, "line held after reset");
        chk(profile, 2'h0, "profile reset");
        apb(1'b0, owh_pkg::OWH_TIMING_OFF, 32'h0000_0000);
        chk(rdata, 32'h0000_0014, "unit reset");
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk(rerr, 1'b1, "unmapped access");
        // full-length cells first, then short ones to keep the run brief
        xfer(8'h15, 1'b0);
        apb(1'b1, owh_pkg::OWH_TIMING_OFF, 32'h0000_0004);
        apb(1'b0, owh_pkg::OWH_TIMING_OFF, 32'h0000_0000);
        chk(rdata, 32'h0000_0004, "unit readback");
        for (int k = 0; k < 6; k++) begin
            r = $random(seed);
            xfer({2'b00, r[5:0]}, r[6]);
        end
        // every profile once, the last with a slow acknowledge
        for (int k = 1; k <= 4; k++) begin
            if (k == 4) ack_cyc <= 16'h1F40;
            xfer({1'b0, 2'b11, 5'h0A}, 1'b0);
            xfer({1'b1, 2'b10, 3'h0, k[1:0]}, 1'b0);
            chk(profile, k[1:0], "profile");
            chk(unlock, 1'b0, "unlock still open");
        end
        ack_cyc <= 16'h00C8;
        xfer({1'b1, 2'b10, 5'h03}, 1'b0);
        chk(profile, 2'h0, "locked write took");
        xfer({1'b0, 2'b11, 5'h0A}, 1'b0);
        xfer(8'h21, 1'b0);
        xfer({1'b0, 2'b10, 5'h02}, 1'b0);
        chk(profile, 2'h0, "second write after unlock took");
        xfer({1'b0, 2'b11, 5'h0B}, 1'b0);
        xfer({1'b0, 2'b10, 5'h01}, 1'b0);
        chk(profile, 2'h0, "bad key unlocked");
        // a second go while busy must not start another transfer
        exp_q.push_back(16'h7221);
        go(8'h21, 1'b0);
        go(8'h3C, 1'b0);
        wait_done(1'b0);
        report_and_stop();
    end
endmodule
